// ---- hw/irq_unit.sv ----
// Vectored two-level interrupt unit with APB register access
`timescale 1ns/1ps
`default_nettype none
module irq_unit (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [irq_unit_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [irq_unit_pkg::NUM_SRC-1:0] flag_a_event,
    input wire logic [irq_unit_pkg::NUM_SRC-1:0] flag_b_event,
    input wire irq_unit_pkg::cpu_status_s cpu,
    output irq_unit_pkg::irq_call_s call
);
    localparam int N = irq_unit_pkg::NUM_SRC;
    localparam int IW = irq_unit_pkg::IDX_W;

    logic [7:0] mask_main_reg;
    logic [7:0] level_main_reg;
    logic [7:0] mask_ext1_reg;
    logic [7:0] level_ext1_reg;
    logic [7:0] mask_ext2_reg;
    logic [7:0] level_ext2_reg;
    logic [N-1:0] pend_a_reg;
    logic [N-1:0] pend_b_reg;
    logic [N-1:0] pend_a_next;
    logic [N-1:0] pend_b_next;
    logic high_active_reg;
    logic low_active_reg;
    logic [IW-1:0] idx_reg;
    logic [IW-1:0] idx_next;
    logic high_reg;
    logic high_next;
    irq_unit_pkg::vec_state_e state_reg;
    irq_unit_pkg::vec_state_e state_next;

    logic access;
    logic wr_en;
    logic mapped;
    logic [31:0] rd_data;
    logic [N-1:0] src_mask;
    logic [N-1:0] src_level;
    logic [N-1:0] pending;
    logic [N-1:0] eligible;
    logic global_en;
    logic pick_valid;
    logic pick_high;
    logic [IW-1:0] pick_idx;
    logic cand_valid;
    logic taken;
    logic [N-1:0] sw_set_a;
    logic [N-1:0] sw_set_b;
    logic [N-1:0] sw_clr_a;
    logic [N-1:0] sw_clr_b;
    logic [N-1:0] hw_clr;

    // Source mask and level vectors from the register bits
    assign src_mask = {mask_ext2_reg[irq_unit_pkg::EXT2_SRC_CNT-1:0], mask_ext1_reg,
        mask_main_reg[irq_unit_pkg::MAIN_SRC_CNT-1:0]};
    assign src_level = {level_ext2_reg[irq_unit_pkg::EXT2_SRC_CNT-1:0], level_ext1_reg,
        level_main_reg[irq_unit_pkg::MAIN_SRC_CNT-1:0]};
    assign global_en = mask_main_reg[irq_unit_pkg::GLOBAL_EN_BIT];

    assign pending = pend_a_reg | pend_b_reg;
    // Level rule: high waits only on high; low waits on any routine
    always_comb begin
        for (int i = 0; i < N; i++) begin
            eligible[i] = global_en && src_mask[i] && pending[i] && !high_active_reg
                && (src_level[i] || !low_active_reg);
        end
    end

    irq_pick #(
        .N(N),
        .IW(IW)
    ) u_pick (
        .req(eligible),
        .level(src_level),
        .valid(pick_valid),
        .is_high(pick_high),
        .idx(pick_idx)
    );

    assign cand_valid = pick_valid;

    // APB decode
    assign access = psel && penable;
    assign wr_en = access && pready && pwrite;
    always_comb begin
        mapped = 1'b1;
        rd_data = 32'h0000_0000;
        case (paddr)
            irq_unit_pkg::OFF_MASK_MAIN: rd_data[7:0] = mask_main_reg;
            irq_unit_pkg::OFF_LEVEL_MAIN: rd_data[7:0] = level_main_reg
                | irq_unit_pkg::LEVEL_MAIN_UNUSED;
            irq_unit_pkg::OFF_MASK_EXT1: rd_data[7:0] = mask_ext1_reg;
            irq_unit_pkg::OFF_LEVEL_EXT1: rd_data[7:0] = level_ext1_reg;
            irq_unit_pkg::OFF_MASK_EXT2: rd_data[7:0] = mask_ext2_reg;
            irq_unit_pkg::OFF_LEVEL_EXT2: rd_data[7:0] = level_ext2_reg;
            irq_unit_pkg::OFF_PEND_A: rd_data[N-1:0] = pend_a_reg;
            irq_unit_pkg::OFF_PEND_A_CLR: rd_data[N-1:0] = pend_a_reg;
            irq_unit_pkg::OFF_PEND_B: rd_data[N-1:0] = pend_b_reg;
            irq_unit_pkg::OFF_PEND_B_CLR: rd_data[N-1:0] = pend_b_reg;
            irq_unit_pkg::OFF_STATUS: rd_data[11:0] = {state_reg, high_active_reg,
                low_active_reg, high_reg, cand_valid, 1'b0, idx_reg};
            default: mapped = 1'b0;
        endcase
    end

    // One wait state, then answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (access && !pready) begin
            pready <= 1'b1;
            prdata <= pwrite ? 32'h0000_0000 : rd_data;
            pslverr <= !mapped;
        end else begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
    end

    // Mask and level registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_main_reg <= irq_unit_pkg::MASK_RESET;
            mask_ext1_reg <= irq_unit_pkg::MASK_RESET;
            mask_ext2_reg <= irq_unit_pkg::MASK_RESET;
            level_main_reg <= irq_unit_pkg::LEVEL_RESET;
            level_ext1_reg <= irq_unit_pkg::LEVEL_RESET;
            level_ext2_reg <= irq_unit_pkg::LEVEL_RESET;
        end else if (wr_en && mapped) begin
            case (paddr)
                irq_unit_pkg::OFF_MASK_MAIN: mask_main_reg <= pwdata[7:0];
                irq_unit_pkg::OFF_LEVEL_MAIN: level_main_reg <= {1'b0, pwdata[6:0]};
                irq_unit_pkg::OFF_MASK_EXT1: mask_ext1_reg <= pwdata[7:0];
                irq_unit_pkg::OFF_LEVEL_EXT1: level_ext1_reg <= pwdata[7:0];
                irq_unit_pkg::OFF_MASK_EXT2: mask_ext2_reg <= {6'h00, pwdata[1:0]};
                irq_unit_pkg::OFF_LEVEL_EXT2: level_ext2_reg <= {6'h00, pwdata[1:0]};
                default: ;
            endcase
        end
    end

    // Pending flags: events and software sets win over clears
    assign sw_set_a = (wr_en && paddr == irq_unit_pkg::OFF_PEND_A) ? pwdata[N-1:0] : '0;
    assign sw_set_b = (wr_en && paddr == irq_unit_pkg::OFF_PEND_B) ? pwdata[N-1:0] : '0;
    assign sw_clr_a = (wr_en && paddr == irq_unit_pkg::OFF_PEND_A_CLR) ? pwdata[N-1:0] : '0;
    assign sw_clr_b = (wr_en && paddr == irq_unit_pkg::OFF_PEND_B_CLR) ? pwdata[N-1:0] : '0;
    assign taken = (state_reg == irq_unit_pkg::ST_REQ) && cpu.call_ack && !cpu.return_from_irq;
    always_comb begin
        hw_clr = '0;
        if (taken) begin
            hw_clr[idx_reg] = irq_unit_pkg::HW_CLEAR_SRC[idx_reg];
        end
    end
    assign pend_a_next = (pend_a_reg & ~sw_clr_a & ~hw_clr) | flag_a_event | sw_set_a;
    assign pend_b_next = (pend_b_reg & ~sw_clr_b & ~hw_clr) | flag_b_event | sw_set_b;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_a_reg <= '0;
            pend_b_reg <= '0;
        end else begin
            pend_a_reg <= pend_a_next;
            pend_b_reg <= pend_b_next;
        end
    end

    // Vectoring sequence
    always_comb begin
        state_next = state_reg;
        idx_next = idx_reg;
        high_next = high_reg;
        case (state_reg)
            irq_unit_pkg::ST_IDLE: begin
                if (cand_valid) begin
                    state_next = irq_unit_pkg::ST_REQ;
                    idx_next = pick_idx;
                    high_next = pick_high;
                end
            end
            irq_unit_pkg::ST_REQ: begin
                if (cpu.return_from_irq) begin
                    state_next = irq_unit_pkg::ST_POST_RETURN;
                end else if (cpu.call_ack) begin
                    state_next = irq_unit_pkg::ST_IDLE;
                end else if (!cand_valid) begin
                    state_next = irq_unit_pkg::ST_IDLE;
                end else begin
                    idx_next = pick_idx;
                    high_next = pick_high;
                end
            end
            irq_unit_pkg::ST_POST_RETURN: begin
                if (cpu.instr_done) begin
                    state_next = irq_unit_pkg::ST_IDLE;
                end
            end
            default: state_next = irq_unit_pkg::ST_IDLE;
        endcase
        if (cpu.return_from_irq) begin
            state_next = irq_unit_pkg::ST_POST_RETURN;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= irq_unit_pkg::ST_IDLE;
            idx_reg <= '0;
            high_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            idx_reg <= idx_next;
            high_reg <= high_next;
        end
    end

    // In-service levels: set on call, newest level cleared on return
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            high_active_reg <= 1'b0;
            low_active_reg <= 1'b0;
        end else if (cpu.return_from_irq) begin
            if (high_active_reg) begin
                high_active_reg <= 1'b0;
            end else begin
                low_active_reg <= 1'b0;
            end
        end else if (taken) begin
            if (high_reg) begin
                high_active_reg <= 1'b1;
            end else begin
                low_active_reg <= 1'b1;
            end
        end
    end

    // Call request toward the CPU
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            call.req <= 1'b0;
            call.high <= 1'b0;
            call.vector <= irq_unit_pkg::RESET_VECTOR;
        end else begin
            call.req <= (state_next == irq_unit_pkg::ST_REQ);
            call.high <= high_next;
            call.vector <= irq_unit_pkg::VECTOR_BASE
                + (16'(idx_next) << irq_unit_pkg::VECTOR_STEP_SHIFT);
        end
    end

    // Checks
    a_req_needs_global: assert property (@(posedge pclk) disable iff (!presetn)
        call.req |-> $past(global_en))
        else $error("request raised while globally disabled");

    a_vector_from_order: assert property (@(posedge pclk) disable iff (!presetn)
        call.req |-> call.vector == irq_unit_pkg::VECTOR_BASE + {8'h00, idx_reg, 3'h0}
            && call.vector <= 16'h0083)
        else $error("vector does not match fixed order");

    a_event_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (|flag_a_event) |=> ((pend_a_reg & $past(flag_a_event)) == $past(flag_a_event)))
        else $error("event did not set pending flag");

    a_hw_clear_on_call: assert property (@(posedge pclk) disable iff (!presetn)
        taken && idx_reg < 5'h04 && !flag_a_event[idx_reg] && !sw_set_a[idx_reg]
            |=> !pend_a_reg[$past(idx_reg)])
        else $error("pending flag not cleared on vectoring");

    a_sw_flag_kept: assert property (@(posedge pclk) disable iff (!presetn)
        taken && idx_reg >= 5'h04 && pend_a_reg[idx_reg] && !sw_clr_a[idx_reg]
            |=> pend_a_reg[$past(idx_reg)])
        else $error("software-cleared flag dropped by hardware");

    a_one_instr_after: assert property (@(posedge pclk) disable iff (!presetn)
        cpu.return_from_irq ##1 (!cpu.instr_done && !cpu.return_from_irq) |=> !call.req)
        else $error("request before one instruction after return");

    a_high_not_preempt: assert property (@(posedge pclk) disable iff (!presetn)
        call.req && !$past(cpu.return_from_irq) |-> !$past(high_active_reg))
        else $error("request raised during high routine");

    a_low_waits: assert property (@(posedge pclk) disable iff (!presetn)
        call.req && $past(low_active_reg) && !$past(cpu.return_from_irq) |-> call.high)
        else $error("low request preempted low routine");

    a_high_first: assert property (@(posedge pclk) disable iff (!presetn)
        pick_valid && (|(eligible & src_level)) |-> pick_high)
        else $error("low level chosen over high level");

    a_fixed_order: assert property (@(posedge pclk) disable iff (!presetn)
        pick_valid |-> !(|(eligible & (pick_high ? src_level : ~src_level)
            & ((17'h00001 << pick_idx) - 17'h00001))))
        else $error("fixed order violated");

    a_detect_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == irq_unit_pkg::ST_IDLE && cand_valid && !cpu.return_from_irq |=> call.req)
        else $error("request not raised one cycle after detect");

    a_return_holds: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == irq_unit_pkg::ST_POST_RETURN && !cpu.instr_done && !cpu.return_from_irq
            |=> state_reg == irq_unit_pkg::ST_POST_RETURN)
        else $error("left post-return wait before instruction end");

    a_return_release: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == irq_unit_pkg::ST_POST_RETURN && cpu.instr_done && !cpu.return_from_irq
            |=> state_reg == irq_unit_pkg::ST_IDLE)
        else $error("post-return wait not released by instruction end");

    a_apb_wait_state: assert property (@(posedge pclk) disable iff (!presetn)
        access && !pready |=> pready ##1 !pready)
        else $error("bus answer not after one wait state");
endmodule : irq_unit
`default_nettype wire

// ---- hw/irq_unit_pkg.sv ----
// Package: register map, field layout and timing constants of the vectored interrupt unit
package irq_unit_pkg;
    localparam int NUM_SRC = 17;
    localparam int IDX_W = 5;
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFF_MASK_MAIN = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_LEVEL_MAIN = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_MASK_EXT1 = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_LEVEL_EXT1 = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_MASK_EXT2 = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_LEVEL_EXT2 = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_PEND_A = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_PEND_A_CLR = 8'h1c;
    localparam logic [ADDR_W-1:0] OFF_PEND_B = 8'h20;
    localparam logic [ADDR_W-1:0] OFF_PEND_B_CLR = 8'h24;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h28;
    localparam int GLOBAL_EN_BIT = 7;
    localparam int MAIN_SRC_CNT = 7;
    localparam int EXT1_FIRST = 7;
    localparam int EXT2_FIRST = 15;
    localparam int EXT2_SRC_CNT = 2;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] LEVEL_RESET = 8'h00;
    localparam logic [7:0] LEVEL_MAIN_UNUSED = 8'h80;
    localparam logic [NUM_SRC-1:0] HW_CLEAR_SRC = 17'h0000f;
    localparam logic [15:0] RESET_VECTOR = 16'h0000;
    localparam logic [15:0] VECTOR_BASE = 16'h0003;
    localparam int VECTOR_STEP_SHIFT = 3;
    localparam int DETECT_CYCLES = 1;
    localparam int LONG_CALL_CYCLES = 5;
    localparam int MIN_RESPONSE_CYCLES = 7;
    localparam int MAX_RESPONSE_CYCLES = 19;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_REQ,
        ST_POST_RETURN
    } vec_state_e;

    typedef struct packed {
        logic instr_done;
        logic return_from_irq;
        logic call_ack;
    } cpu_status_s;

    typedef struct packed {
        logic req;
        logic high;
        logic [15:0] vector;
    } irq_call_s;
endpackage : irq_unit_pkg

// ---- hw/irq_pick.sv ----
// Priority resolver: high level first, then lowest fixed order
`timescale 1ns/1ps
`default_nettype none
module irq_pick #(
    parameter int N = 17,
    parameter int IW = 5
) (
    input wire logic [N-1:0] req,
    input wire logic [N-1:0] level,
    output logic valid,
    output logic is_high,
    output logic [IW-1:0] idx
);
    logic any_high;

    always_comb begin
        any_high = |(req & level);
        valid = 1'b0;
        is_high = 1'b0;
        idx = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i] && (level[i] || !any_high)) begin
                valid = 1'b1;
                is_high = level[i];
                idx = IW'(i);
            end
        end
    end
endmodule : irq_pick
`default_nettype wire

// ---- sim/cpu_model.sv ----
// CPU sequencer model that answers the interrupt unit
`timescale 1ns/1ps
`default_nettype none
module cpu_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire irq_unit_pkg::irq_call_s call,
    input wire logic ack_en,
    input wire logic return_go,
    output var irq_unit_pkg::cpu_status_s cpu
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu <= '0;
        end else begin
            cpu.instr_done <= ~cpu.instr_done;
            cpu.return_from_irq <= return_go;
            cpu.call_ack <= call.req && ack_en && !cpu.call_ack;
        end
    end
endmodule : cpu_model
`default_nettype wire

// ---- sim/testbench.sv ----
// Self-checking bench for the vectored interrupt unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [16:0] fa = 17'h0;
    logic [16:0] fb = 17'h0;
    irq_unit_pkg::cpu_status_s cpu;
    irq_unit_pkg::irq_call_s call;
    logic ack_en = 1'b0;
    logic return_go = 1'b0;
    int n_errors = 0;
    int tests_run = 0;
    int cyc = 0;
    logic [31:0] seed = 32'h1e;
    logic [31:0] rd;
    logic err;

    irq_unit dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .flag_a_event(fa), .flag_b_event(fb), .cpu(cpu), .call(call));
    cpu_model cpu_u (.pclk(pclk), .presetn(presetn), .call(call), .ack_en(ack_en),
        .return_go(return_go), .cpu(cpu));

    always #20 pclk = ~pclk;

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            conclude();
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    // Lowest order wins, high level before low
    function automatic logic [4:0] pick(input logic [16:0] r, input logic [16:0] lv);
        pick = 5'h00;
        for (int i = 16; i >= 0; i--) if (r[i]) pick = 5'(i);
        for (int i = 16; i >= 0; i--) if (r[i] && lv[i]) pick = 5'(i);
    endfunction : pick

    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : check

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        check("apb_wait", 32'h2, 32'(n));
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(nm, e, rd);
    endtask : rchk

    task automatic fire(input logic [16:0] a, input logic [16:0] b);
        @(posedge pclk);
        fa <= a;
        fb <= b;
        @(posedge pclk);
        fa <= 17'h0;
        fb <= 17'h0;
    endtask : fire

    task automatic wreq(input logic e);
        int n;
        n = 0;
        #1;
        while (call.req !== e && n < 40) begin
            @(posedge pclk);
            #1;
            n++;
        end
        check("call_req", {31'h0, e}, {31'h0, call.req});
    endtask : wreq

    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
        #1;
        check("req_idle", 32'h0, {31'h0, call.req});
    endtask : idle

    task automatic ack;
        @(posedge pclk);
        ack_en <= 1'b1;
        wreq(1'b0);
        @(posedge pclk);
        ack_en <= 1'b0;
    endtask : ack

    task automatic ret_irq;
        @(posedge pclk);
        return_go <= 1'b1;
        @(posedge pclk);
        return_go <= 1'b0;
    endtask : ret_irq

    task automatic en(input logic [16:0] m, input logic [16:0] l);
        apb(1'b1, irq_unit_pkg::OFF_MASK_MAIN, {24'h0, 1'b1, m[6:0]});
        apb(1'b1, irq_unit_pkg::OFF_LEVEL_MAIN, {25'h0, l[6:0]});
        apb(1'b1, irq_unit_pkg::OFF_MASK_EXT1, {24'h0, m[14:7]});
        apb(1'b1, irq_unit_pkg::OFF_LEVEL_EXT1, {24'h0, l[14:7]});
        apb(1'b1, irq_unit_pkg::OFF_MASK_EXT2, {30'h0, m[16:15]});
        apb(1'b1, irq_unit_pkg::OFF_LEVEL_EXT2, {30'h0, l[16:15]});
    endtask : en

    task automatic clr(input logic [31:0] m);
        apb(1'b1, irq_unit_pkg::OFF_PEND_A_CLR, m);
        apb(1'b1, irq_unit_pkg::OFF_PEND_B_CLR, m);
    endtask : clr

    task automatic conclude;
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude

    initial begin
        logic [16:0] lv;
        logic [16:0] r;
        logic [4:0] w;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        #1 check("vector", 32'h0, {16'h0, call.vector});
        rchk("mask_main", irq_unit_pkg::OFF_MASK_MAIN, 32'h0);
        rchk("level_main", irq_unit_pkg::OFF_LEVEL_MAIN, 32'h80);
        rchk("level_ext1", irq_unit_pkg::OFF_LEVEL_EXT1, 32'h0);
        rchk("level_ext2", irq_unit_pkg::OFF_LEVEL_EXT2, 32'h0);
        rchk("status", irq_unit_pkg::OFF_STATUS, 32'h0);
        apb(1'b1, 8'h3c, 32'hff);
        check("slverr", 32'h1, {31'h0, err});
        $display("test reset done");
        en(17'h1ffff, 17'h0);
        for (int i = 0; i < 17; i++) begin
            fire(i[0] ? 17'h0 : 17'h1 << i, i[0] ? 17'h1 << i : 17'h0);
            #1 check("early", 32'h0, {31'h0, call.req});
            @(posedge pclk);
            #1 check("req", 32'h1, {31'h0, call.req});
            check("vec", 32'h3 + 32'(i) * 8, {16'h0, call.vector});
            ack();
            rchk("pend", i[0] ? irq_unit_pkg::OFF_PEND_B : irq_unit_pkg::OFF_PEND_A,
                i >= 4 ? 32'h1 << i : 32'h0);
            ret_irq();
            repeat (8) @(posedge pclk);
            #1 check("again", 32'(i >= 4), {31'h0, call.req});
            clr(32'h1ffff);
            wreq(1'b0);
        end
        $display("test vectors done");
        apb(1'b1, irq_unit_pkg::OFF_MASK_MAIN, 32'h0);
        fire(17'h20, 17'h0);
        idle(4);
        rchk("pend_masked", irq_unit_pkg::OFF_PEND_A, 32'h20);
        apb(1'b1, irq_unit_pkg::OFF_MASK_MAIN, 32'h20);
        idle(4);
        apb(1'b1, irq_unit_pkg::OFF_MASK_MAIN, 32'ha0);
        wreq(1'b1);
        clr(32'h1ffff);
        wreq(1'b0);
        en(17'h1ffff, 17'h0);
        apb(1'b1, irq_unit_pkg::OFF_PEND_B, 32'h1000);
        wreq(1'b1);
        check("soft_vec", 32'h63, {16'h0, call.vector});
        clr(32'h1ffff);
        wreq(1'b0);
        $display("test enables done");
        for (int k = 0; k < 8; k++) begin
            seed = xs(seed);
            lv = seed[16:0];
            seed = xs(seed);
            r = (17'h1 << seed[3:0]) | (17'h1 << (seed[8:4] % 17));
            if (k == 0) begin
                r = 17'h10001;
                lv = 17'h0;
            end
            en(17'h1ffff, lv);
            rchk("level_ext1", irq_unit_pkg::OFF_LEVEL_EXT1, {24'h0, lv[14:7]});
            fire(r, 17'h0);
            wreq(1'b1);
            w = pick(r, lv);
            check("pick_vec", 32'h3 + 32'(w) * 8, {16'h0, call.vector});
            check("pick_high", {31'h0, lv[w]}, {31'h0, call.high});
            clr(32'h1ffff);
            wreq(1'b0);
        end
        $display("test priority done");
        en(17'h1ffff, 17'h300);
        fire(17'h10, 17'h0);
        wreq(1'b1);
        ack();
        fire(17'h20, 17'h0);
        idle(6);
        fire(17'h100, 17'h0);
        wreq(1'b1);
        check("preempt", 32'h43, {16'h0, call.vector});
        ack();
        rchk("status_nest", irq_unit_pkg::OFF_STATUS, 32'h388);
        clr(32'h110);
        fire(17'h200, 17'h0);
        idle(6);
        ret_irq();
        idle(2);
        wreq(1'b1);
        check("high_next", 32'h4b, {16'h0, call.vector});
        ack();
        clr(32'h200);
        ret_irq();
        idle(8);
        ret_irq();
        wreq(1'b1);
        check("low_next", 32'h2b, {16'h0, call.vector});
        clr(32'h1ffff);
        wreq(1'b0);
        $display("test nesting done");
        conclude();
    end
endmodule : testbench
`default_nettype wire
